// >>> sim/ccp_clock_power_ctrl_test.sv
// Purpose: register, clock, flash strobe and on/off tests
// Assumes: debounce 20 and reset window 4 cycles in sim
// Notes:   ends on verdict or watchdog
`timescale 1ns/1ps
module ccp_clock_power_ctrl_test;
	import ccp_pkg::*;
	logic           clk, rst_b, press, card_on, bus_pwr, wake, fin, fout;
	logic           psw_b, card_act, e;
	logic [31:0]    d;
	int             err_total, n_tests, n;
	ccp_apb_req_t   req;
	ccp_apb_rsp_t   rsp;
	ccp_clk_ctrl_t  cc;
	ccp_pwr_ctrl_t  pc;
	ccp_clock_power_ctrl #(.DEBOUNCE_CYC(20), .POR_CYC(4))
	u_ccp_clock_power_ctrl (.clk, .rst_b, .apb_req(req), .apb_rsp(rsp),
		.power_switch_b(psw_b), .bus_power_present(bus_pwr),
		.wake_event(wake), .card_active(card_act), .flash_read_in(fin),
		.flash_read_out(fout), .clk_ctrl(cc), .pwr_ctrl(pc));
	ccp_switch_model u_ccp_switch_model (.clk, .rst_b, .press,
		.card_on, .card_deactivate(pc.card_deactivate),
		.power_switch_b(psw_b), .card_active(card_act));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [17:0] i,
		input logic [7:0] wd);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, {i, 2'b00}, {24'h00_0000, wd}};
		@(posedge clk);
		req.penable <= 1'b1;
		// no cycle count assumed; waits for pready, with the watchdog as the only bound
		do begin
			@(posedge clk);
		end while (rsp.pready !== 1'b1);
		d = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask : apb
	task automatic rdchk(input logic [17:0] i, input logic [7:0] x);
		apb(1'b0, i, 8'h00);
		chk(d, {24'h00_0000, x});
	endtask : rdchk
	task automatic hold(input int c);
		press <= 1'b1;
		repeat (c) @(posedge clk);
		press <= 1'b0;
	endtask : hold
	task automatic wait_off;
		n = 0;
		while (pc.vdd_enable !== 1'b0 && n < 60) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_off
	task automatic pulse(input logic [7:0] m, input int x);
		int w;
		w = 0;
		apb(1'b1, CCP_IDX_FLASH_PULSE, m);
		fin <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			if (i == 11) fin <= 1'b0;
			w += (fout === 1'b1) ? 1 : 0;
		end
		chk(w, x);
	endtask : pulse
	task automatic stop_test;
		if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	initial begin
		repeat (4000) @(posedge clk);
		err_total++;
		stop_test();
	end
	initial begin
		{rst_b, press, card_on, bus_pwr, wake, fin} = '0;
		req = '0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		chk(pc.vdd_enable, 1'b0);
		rdchk(CCP_IDX_CLK_RATIO, 8'h0a);
		rdchk(CCP_IDX_FLASH_PULSE, 8'h10);
		rdchk(CCP_IDX_POWER_CTRL, 8'h00);
		apb(1'b0, 18'h0_0001, 8'h00);
		chk(e, 1'b1);
		hold(40);
		repeat (8) @(posedge clk);
		chk(pc.vdd_enable, 1'b1);
		chk(cc.vco_ratio, 5'h08);
		rdchk(CCP_IDX_POWER_CTRL, 8'h10);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, CCP_IDX_CLK_RATIO, 8'(c));
			repeat (2) @(posedge clk);
			chk(cc.vco_ratio, 32'(2 * c + 4));
		end
		apb(1'b1, CCP_IDX_CLK_RATIO, 8'he2);
		repeat (2) @(posedge clk);
		chk({cc.osc_pll_run, cc.keypad_clk_en, cc.card_clk_en,
			cc.card_detect_en}, 4'h1);
		rdchk(CCP_IDX_CLK_RATIO, 8'he2);
		apb(1'b1, CCP_IDX_CLK_RATIO, 8'h02);
		apb(1'b1, CCP_IDX_POWER_CTRL, 8'h01);
		repeat (2) @(posedge clk);
		chk({cc.osc_pll_run, cc.keypad_clk_en, cc.card_clk_en,
			cc.card_detect_en}, 4'h1);
		rdchk(CCP_IDX_CLK_RATIO, 8'h02);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		repeat (3) @(posedge clk);
		chk({cc.osc_pll_run, cc.keypad_clk_en, cc.card_clk_en,
			cc.card_detect_en}, 4'hf);
		pulse(8'h00, 5);
		pulse(8'h10, 8);
		pulse(8'h20, 12);
		pulse(8'h30, 12);
		card_on <= 1'b1;
		@(posedge clk);
		card_on <= 1'b0;
		hold(30);
		repeat (30) @(posedge clk);
		chk(pc.off_req, 1'b1);
		rdchk(CCP_IDX_POWER_CTRL, 8'h14);
		apb(1'b1, CCP_IDX_POWER_CTRL, 8'h02);
		repeat (3) @(posedge clk);
		chk({pc.card_deactivate, pc.vdd_enable}, 2'h3);
		wait_off();
		// request clears one edge after off, output one edge later
		repeat (2) @(posedge clk);
		chk({pc.vdd_enable, pc.off_req}, 2'h0);
		rdchk(CCP_IDX_POWER_CTRL, 8'h00);
		bus_pwr <= 1'b1;
		repeat (4) @(posedge clk);
		chk(pc.vdd_enable, 1'b1);
		hold(30);
		repeat (10) @(posedge clk);
		chk(pc.off_req, 1'b0);
		rdchk(CCP_IDX_POWER_CTRL, 8'h18);
		apb(1'b1, CCP_IDX_POWER_CTRL, 8'h02);
		repeat (6) @(posedge clk);
		chk(pc.vdd_enable, 1'b1);
		bus_pwr <= 1'b0;
		repeat (2) @(posedge clk);
		apb(1'b1, CCP_IDX_POWER_CTRL, 8'h02);
		wait_off();
		chk(pc.vdd_enable, 1'b0);
		stop_test();
	end
endmodule : ccp_clock_power_ctrl_test

// >>> sim/ccp_cpc_asserts.sv
// Purpose: port checker for clock and power control
// Assumes: short debounce and reset counts handed on by bind
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
module ccp_cpc_asserts
	import ccp_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYC = 20,
	parameter int unsigned POR_CYC      = 4
) (
	input wire logic              clk,
	input wire logic              rst_b,
	input ccp_pkg::ccp_apb_req_t  apb_req,
	input ccp_pkg::ccp_apb_rsp_t  apb_rsp,
	input wire logic              power_switch_b,
	input wire logic              bus_power_present,
	input wire logic              card_active,
	input ccp_pkg::ccp_clk_ctrl_t clk_ctrl,
	input ccp_pkg::ccp_pwr_ctrl_t pwr_ctrl
);
	int unsigned lo_q;
	int unsigned por_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) lo_q <= 0;
		else lo_q <= power_switch_b ? 0 : lo_q + 1;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) por_q <= 0;
		else por_q <= pwr_ctrl.por_active ? por_q + 1 : 0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_ratio;
		pwr_ctrl.vdd_enable && $past(pwr_ctrl.vdd_enable) &&
		$stable(clk_ctrl.pll_multiplier_count) |-> clk_ctrl.vco_ratio ==
		{1'b0, clk_ctrl.pll_multiplier_count, 1'b0} + 5'h04;
	endproperty
	a_ratio: assert property (p_ratio) else $error("bad vco ratio");
	property p_apb_ans;
		apb_req.psel && !apb_req.penable |=>
		apb_rsp.pready ##1 !apb_rsp.pready;
	endproperty
	a_apb_ans: assert property (p_apb_ans) else $error("bad apb answer");
	property p_apb_err;
		apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0;
	endproperty
	a_apb_err: assert property (p_apb_err) else $error("bad apb error");
	property p_bus_on;
		bus_power_present [*4] |-> pwr_ctrl.vdd_enable;
	endproperty
	a_bus_on: assert property (p_bus_on) else $error("not on");
	// a rise needs a full debounce run or bus power behind it
	property p_deb;
		$rose(pwr_ctrl.vdd_enable) |-> $past(bus_power_present, 2) ||
		$past(lo_q, 2) >= DEBOUNCE_CYC - 1;
	endproperty
	a_deb: assert property (p_deb) else $error("early turn on");
	property p_por;
		$fell(pwr_ctrl.por_active) |-> por_q == POR_CYC;
	endproperty
	a_por: assert property (p_por) else $error("bad por width");
	property p_req_hold;
		$fell(pwr_ctrl.off_req) |-> ##[0:2] !pwr_ctrl.vdd_enable;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("req lost");
	property p_off_order;
		$fell(pwr_ctrl.vdd_enable) |-> !$past(pwr_ctrl.analog_enable) &&
		!$past(card_active, 3);
	endproperty
	a_off_order: assert property (p_off_order) else $error("off order");
	property p_deact;
		pwr_ctrl.card_deactivate |->
		pwr_ctrl.vdd_enable && pwr_ctrl.analog_enable;
	endproperty
	a_deact: assert property (p_deact) else $error("bad deactivate");
	property p_detect;
		pwr_ctrl.vdd_enable && $past(pwr_ctrl.vdd_enable) |->
		clk_ctrl.card_detect_en;
	endproperty
	a_detect: assert property (p_detect) else $error("detect off");
endmodule : ccp_cpc_asserts

bind ccp_clock_power_ctrl ccp_cpc_asserts #(
	.DEBOUNCE_CYC(DEBOUNCE_CYC), .POR_CYC(POR_CYC)
) u_ccp_cpc_asserts (.clk, .rst_b, .apb_req, .apb_rsp, .power_switch_b,
	.bus_power_present, .card_active, .clk_ctrl, .pwr_ctrl);

// >>> sim/ccp_switch_model.sv
// Purpose: momentary switch and card side seen by the block
// Assumes: switch to ground with pull-up
// Notes:   card side takes six cycles to finish deactivation
`timescale 1ns/1ps
module ccp_switch_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic press,
	input wire logic card_on,
	input wire logic card_deactivate,
	output logic     power_switch_b,
	output logic     card_active
);
	logic [2:0] lag_q;
	// open contact reads high through the pull-up
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) power_switch_b <= 1'b1;
		else power_switch_b <= !press;
	end
	// slow on purpose so the wait for the card is exercised
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			card_active <= 1'b0;
			lag_q <= 3'h0;
		end else if (card_on) begin
			card_active <= 1'b1;
			lag_q <= 3'h0;
		end else if (card_deactivate && card_active) begin
			lag_q <= lag_q + 3'h1;
			card_active <= lag_q != 3'h5;
		end
	end
endmodule : ccp_switch_model

// >>> src/ccp_clock_power_ctrl.sv
// Purpose: clock ratio, clock gating and power on/off control
// Assumes: APB slave, zero wait state; switch input active low
// Notes:   rst_b stands for first application of power
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module ccp_clock_power_ctrl
	import ccp_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYC = ccp_pkg::CCP_DEBOUNCE_CYC,
	parameter int unsigned POR_CYC      = ccp_pkg::CCP_POR_CYC
) (
	input  wire logic           clk,
	input  wire logic           rst_b,
	input  ccp_pkg::ccp_apb_req_t apb_req,
	output ccp_pkg::ccp_apb_rsp_t apb_rsp,
	input  wire logic           power_switch_b,
	input  wire logic           bus_power_present,
	input  wire logic           wake_event,
	input  wire logic           card_active,
	input  wire logic           flash_read_in,
	output logic                flash_read_out,
	output ccp_pkg::ccp_clk_ctrl_t clk_ctrl,
	output ccp_pkg::ccp_pwr_ctrl_t pwr_ctrl
);
	import ccp_pkg::*;

	localparam int unsigned DW = $clog2(DEBOUNCE_CYC + 1);
	localparam logic [DW-1:0] DEB_LAST = DW'(DEBOUNCE_CYC - 1);
	localparam int unsigned PW = $clog2(POR_CYC + 1);
	localparam logic [PW-1:0] POR_LOAD = PW'(POR_CYC);

	// register state
	logic [7:0]     clk_ratio_q;
	logic [7:0]     flash_pulse_q;
	logic           power_down_q;
	logic           off_ack_q;
	ccp_pwr_state_t state_q;
	ccp_pwr_state_t state_d;
	logic           off_req_q;
	logic [DW-1:0]  deb_cnt_q;
	logic           sw_armed_q;
	logic           deb_done;
	logic [PW-1:0]  por_cnt_q;
	ccp_apb_rsp_t   rsp_q;
	ccp_clk_ctrl_t  clk_ctrl_q;
	ccp_pwr_ctrl_t  pwr_ctrl_q;

	// bus decode
	logic [17:0] idx;
	logic        hit_ratio;
	logic        hit_pulse;
	logic        hit_power;
	logic        mapped;
	logic        setup;
	logic        wr_go;
	logic        powered;
	logic [7:0]  power_rd;

	assign idx       = apb_req.paddr[CCP_ADDR_W-1:2];
	assign hit_ratio = (idx == CCP_IDX_CLK_RATIO);
	assign hit_pulse = (idx == CCP_IDX_FLASH_PULSE);
	assign hit_power = (idx == CCP_IDX_POWER_CTRL);
	assign mapped    = hit_ratio | hit_pulse | hit_power;
	assign setup     = apb_req.psel & ~apb_req.penable;
	// writes land at the completing edge only; pready is high there
	// writes while unpowered are dropped so no stale ack survives
	assign wr_go     = apb_req.psel & apb_req.penable & apb_req.pwrite &
	                   rsp_q.pready & mapped & powered;
	// logic supply present: anything but the off state
	assign powered   = (state_q != CCP_PWR_OFF);

	assign power_rd = {2'b00, state_q, bus_power_present, off_req_q,
	                   off_ack_q, power_down_q};

	// APB answer: computed in setup, presented through the access phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rsp_q <= '0;
		end else if (setup) begin
			rsp_q.pready  <= 1'b1;
			rsp_q.pslverr <= ~mapped;
			rsp_q.prdata  <= 32'h0000_0000;
			if (!apb_req.pwrite) begin
				if (hit_ratio) begin
					rsp_q.prdata <= {24'h00_0000, clk_ratio_q};
				end else if (hit_pulse) begin
					rsp_q.prdata <= {24'h00_0000, flash_pulse_q};
				end else if (hit_power) begin
					rsp_q.prdata <= {24'h00_0000, power_rd};
				end
			end
		end else begin
			rsp_q.pready  <= 1'b0;
			rsp_q.pslverr <= 1'b0;
		end
	end

	// clock ratio and gating register; reinitialised while unpowered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_ratio_q <= CCP_CLK_RATIO_RST;
		end else if (!powered) begin
			clk_ratio_q <= CCP_CLK_RATIO_RST;
		end else if (wr_go && hit_ratio) begin
			clk_ratio_q <= apb_req.pwdata[7:0] & CCP_CLK_RATIO_WMASK;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flash_pulse_q <= CCP_FLASH_PULSE_RST;
		end else if (!powered) begin
			flash_pulse_q <= CCP_FLASH_PULSE_RST;
		end else if (wr_go && hit_pulse) begin
			flash_pulse_q <= apb_req.pwdata[7:0] & CCP_FLASH_PULSE_WMASK;
		end
	end

	// power-down: software sets, wake event clears; the set wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			power_down_q <= 1'b0;
		end else if (!powered) begin
			power_down_q <= 1'b0;
		end else if (wr_go && hit_power &&
		             apb_req.pwdata[CCP_POWER_DOWN_BIT_BIT]) begin
			power_down_q <= 1'b1;
		end else if (wr_go && hit_power) begin
			power_down_q <= 1'b0;
		end else if (wake_event) begin
			power_down_q <= 1'b0;
		end
	end

	// acknowledge is write-one; it stays until the shutdown is done or bus power is seen in the on state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			off_ack_q <= 1'b0;
		end else if (wr_go && hit_power &&
		             apb_req.pwdata[CCP_OFF_ACK_BIT]) begin
			off_ack_q <= 1'b1;
		end else if (state_q == CCP_PWR_OFF ||
		             (state_q == CCP_PWR_ON && bus_power_present)) begin
			off_ack_q <= 1'b0;
		end
	end

	// switch debounce; a press that turned us on must be released
	// before it can count as a shutdown request
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			deb_cnt_q <= '0;
		end else if (power_switch_b || !sw_armed_q ||
		             bus_power_present) begin
			deb_cnt_q <= '0;
		end else if (deb_cnt_q != DEB_LAST) begin
			deb_cnt_q <= deb_cnt_q + DW'(1);
		end
	end

	assign deb_done = sw_armed_q && !power_switch_b &&
	                  !bus_power_present && (deb_cnt_q == DEB_LAST);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_armed_q <= 1'b1;
		end else if (power_switch_b) begin
			sw_armed_q <= 1'b1;
		end else if (deb_done) begin
			sw_armed_q <= 1'b0;
		end
	end

	// power state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			CCP_PWR_OFF: begin
				if (bus_power_present) begin
					state_d = CCP_PWR_ON;
				end else if (deb_done) begin
					state_d = CCP_PWR_ON;
				end
			end
			CCP_PWR_ON: begin
				if (off_ack_q && !bus_power_present) begin
					state_d = CCP_PWR_DEACT;
				end
			end
			CCP_PWR_DEACT: begin
				// card sequencer must finish before supplies drop
				if (bus_power_present) begin
					state_d = CCP_PWR_ON;
				end else if (!card_active) begin
					state_d = CCP_PWR_DOWN;
				end
			end
			CCP_PWR_DOWN: begin
				state_d = bus_power_present ? CCP_PWR_ON : CCP_PWR_OFF;
			end
			default: begin
				state_d = CCP_PWR_OFF;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= CCP_PWR_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// held shutdown request; release of the switch does not clear it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			off_req_q <= 1'b0;
		end else if (state_q == CCP_PWR_ON && deb_done) begin
			off_req_q <= 1'b1;
		end else if (state_q == CCP_PWR_OFF) begin
			off_req_q <= 1'b0;
		end
	end

	// power-on reset window after each off to on step
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			por_cnt_q <= '0;
		end else if (state_q == CCP_PWR_OFF && state_d == CCP_PWR_ON) begin
			por_cnt_q <= POR_LOAD;
		end else if (por_cnt_q != '0) begin
			por_cnt_q <= por_cnt_q - PW'(1);
		end
	end

	// clock outputs, all registered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_ctrl_q <= '0;
		end else begin
			clk_ctrl_q.osc_pll_run <= powered &&
				!clk_ratio_q[CCP_OSC_DIS_BIT] &&
				!power_down_q;
			clk_ctrl_q.keypad_clk_en <= powered &&
				!clk_ratio_q[CCP_KPD_DIS_BIT] && !power_down_q;
			clk_ctrl_q.card_clk_en <= powered &&
				!clk_ratio_q[CCP_CARD_DIS_BIT] && !power_down_q;
			// detection ignores the card clock gate
			clk_ctrl_q.card_detect_en <= powered;
			clk_ctrl_q.pll_multiplier_count <=
				clk_ratio_q[CCP_MULT_LSB +: CCP_MULT_W];
			clk_ctrl_q.vco_ratio <=
				CCP_RATIO_MUL * {2'b00,
				clk_ratio_q[CCP_MULT_LSB +: CCP_MULT_W]} +
				CCP_RATIO_BASE;
		end
	end

	// power outputs, all registered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_ctrl_q <= '0;
		end else begin
			pwr_ctrl_q.vdd_enable      <= powered;
			pwr_ctrl_q.analog_enable   <= (state_q == CCP_PWR_ON) ||
			                              (state_q == CCP_PWR_DEACT);
			pwr_ctrl_q.por_active      <= (por_cnt_q != '0);
			pwr_ctrl_q.off_req         <= off_req_q;
			pwr_ctrl_q.card_deactivate <= (state_q == CCP_PWR_DEACT) &&
			                              card_active;
		end
	end

	// flash read one-shot; idle while the logic supply is off
	ccp_read_shortener #(
		.SHORT_CYC (CCP_READ_SHORT_CYC),
		.LONG_CYC  (CCP_READ_LONG_CYC)
	) u_ccp_read_shortener (
		.clk         (clk),
		.rst_b       (rst_b),
		.read_in     (flash_read_in & powered),
		.passthrough (flash_pulse_q[CCP_PASS_BIT]),
		.long_sel    (flash_pulse_q[CCP_LONG_BIT]),
		.read_out    (flash_read_out)
	);

	assign apb_rsp  = rsp_q;
	assign clk_ctrl = clk_ctrl_q;
	assign pwr_ctrl = pwr_ctrl_q;

endmodule : ccp_clock_power_ctrl

// >>> src/ccp_pkg.sv
// Purpose: shared constants and carriers for clock and power control
// Assumes: 125 MHz system clock, APB register access
// Notes:   printed offsets are register indices; byte address is 4x
package ccp_pkg;

	localparam int unsigned CCP_ADDR_W = 20;

	// register indices as printed; byte address is four times the index
	localparam logic [17:0] CCP_IDX_CLK_RATIO  = 18'h0_008f;
	localparam logic [17:0] CCP_IDX_FLASH_PULSE = 18'h0_fff2;
	localparam logic [17:0] CCP_IDX_POWER_CTRL = 18'h0_0100;

	// clock_ratio_and_gating fields
	localparam int unsigned CCP_OSC_DIS_BIT  = 7;
	localparam int unsigned CCP_KPD_DIS_BIT  = 6;
	localparam int unsigned CCP_CARD_DIS_BIT = 5;
	localparam int unsigned CCP_MULT_LSB     = 0;
	localparam int unsigned CCP_MULT_W       = 3;
	localparam logic [7:0]  CCP_CLK_RATIO_RST = 8'h0a;
	localparam logic [7:0]  CCP_CLK_RATIO_WMASK = 8'he7;

	// flash_read_pulse_control fields
	localparam int unsigned CCP_PASS_BIT      = 5;
	localparam int unsigned CCP_LONG_BIT      = 4;
	localparam logic [7:0]  CCP_FLASH_PULSE_RST = 8'h10;
	localparam logic [7:0]  CCP_FLASH_PULSE_WMASK = 8'h30;

	// power control register fields
	localparam int unsigned CCP_POWER_DOWN_BIT_BIT   = 0;
	localparam int unsigned CCP_OFF_ACK_BIT = 1;
	localparam int unsigned CCP_OFF_REQ_BIT = 2;
	localparam int unsigned CCP_VBUS_BIT    = 3;
	localparam int unsigned CCP_STATE_LSB   = 4;
	localparam logic [7:0]  CCP_POWER_CTRL_RST = 8'h00;

	// ratio: vco = crystal * (2 * count + 4)
	localparam logic [4:0]  CCP_RATIO_MUL  = 5'h02;
	localparam logic [4:0]  CCP_RATIO_BASE = 5'h04;

	// timing
	localparam int unsigned CCP_CLK_PERIOD_NS = 8;
	localparam int unsigned CCP_READ_SHORT_NS = 40;
	localparam int unsigned CCP_READ_LONG_NS  = 66;
	localparam int unsigned CCP_READ_SHORT_CYC =
		(CCP_READ_SHORT_NS / CCP_CLK_PERIOD_NS < 1) ? 1 :
		CCP_READ_SHORT_NS / CCP_CLK_PERIOD_NS;
	localparam int unsigned CCP_READ_LONG_CYC =
		(CCP_READ_LONG_NS / CCP_CLK_PERIOD_NS < 1) ? 1 :
		CCP_READ_LONG_NS / CCP_CLK_PERIOD_NS;
	localparam int unsigned CCP_DEBOUNCE_MS = 50;
	localparam int unsigned CCP_DEBOUNCE_CYC =
		(CCP_DEBOUNCE_MS * 1000000 + CCP_CLK_PERIOD_NS - 1) /
		CCP_CLK_PERIOD_NS;
	localparam int unsigned CCP_POR_CYC = 16;

	typedef enum logic [1:0] {
		CCP_PWR_OFF   = 2'b00,
		CCP_PWR_ON    = 2'b01,
		CCP_PWR_DEACT = 2'b11,
		CCP_PWR_DOWN  = 2'b10
	} ccp_pwr_state_t;

	typedef struct packed {
		logic                  psel;
		logic                  penable;
		logic                  pwrite;
		logic [CCP_ADDR_W-1:0] paddr;
		logic [31:0]           pwdata;
	} ccp_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ccp_apb_rsp_t;

	typedef struct packed {
		logic       osc_pll_run;
		logic       keypad_clk_en;
		logic       card_clk_en;
		logic       card_detect_en;
		logic [2:0] pll_multiplier_count;
		logic [4:0] vco_ratio;
	} ccp_clk_ctrl_t;

	typedef struct packed {
		logic vdd_enable;
		logic analog_enable;
		logic por_active;
		logic off_req;
		logic card_deactivate;
	} ccp_pwr_ctrl_t;

endpackage : ccp_pkg

// >>> src/ccp_read_shortener.sv
// Purpose: one-shot that trims the flash read strobe to a fixed width
// Assumes: read strobe synchronous to clk
// Notes:   width counts are whole clock cycles
`timescale 1ns/1ps
module ccp_read_shortener #(
	parameter int unsigned SHORT_CYC = 5,
	parameter int unsigned LONG_CYC  = 8
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic read_in,
	input  wire logic passthrough,
	input  wire logic long_sel,
	output logic      read_out
);
	localparam int unsigned CW = $clog2(LONG_CYC + 1);
	localparam logic [CW-1:0] SHORT_LOAD = CW'(SHORT_CYC - 1);
	localparam logic [CW-1:0] LONG_LOAD  = CW'(LONG_CYC - 1);

	logic          read_prev_q;
	logic [CW-1:0] cnt_q;
	logic          out_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			read_prev_q <= 1'b0;
		end else begin
			read_prev_q <= read_in;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_q <= 1'b0;
			cnt_q <= '0;
		end else if (passthrough) begin
			out_q <= read_in;
			cnt_q <= '0;
		end else if (!read_in) begin
			// never stretches past the source strobe
			out_q <= 1'b0;
			cnt_q <= '0;
		end else if (!read_prev_q) begin
			out_q <= 1'b1;
			cnt_q <= long_sel ? LONG_LOAD : SHORT_LOAD;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - CW'(1);
		end else begin
			out_q <= 1'b0;
		end
	end

	assign read_out = out_q;

endmodule : ccp_read_shortener
